// ==== logic/irad_decoder.sv ====
// Purpose: internal register window decode and controller routing
// Assumes: one request per cycle from the internal bus, same clock
// Notes:   route outputs are registered, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Decode full 32-bit physical address.
// - 64 KB window, reset base, relocatable.
// - Default and relocated bases alias registers.
// - Uncached one-to-one region flag.
// - After reset only window and boot mapped.
// - Other resources placed by their controllers.
// - Satellite config cycles any size, little-endian.
// - Reserved offsets select no controller.
// - Memory and external bus controller ranges.
// - Highway, DMA and NAND flash ranges.
// - PCI bridge and chip setup ranges.
// - Three timer units, 256 bytes each.
// - Two serial port ranges.
// - Parallel port and interrupt controller ranges.
// - Audio link, SPI and clock ranges.
// - Relocation pointer at setup offset 0xE030.
module irad_decoder (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire irad_pkg::irad_req_t   req,
  input  wire logic                  pci_satellite,
  input  wire logic                  pci_cfg_valid,
  input  wire logic                  pci_cfg_write,
  input  wire logic [7:0]            pci_cfg_ofs,
  input  wire logic [3:0]            pci_cfg_be,
  input  wire logic [31:0]           pci_cfg_wdata,
  input  wire logic                  sys_big_endian,
  output irad_pkg::irad_route_t      route,
  output logic                       hit,
  output logic                       uncached,
  output logic [31:0]                reloc_base,
  output logic                       cfg_valid,
  output logic                       cfg_write,
  output logic [15:0]                cfg_ofs,
  output logic [3:0]                 cfg_be,
  output logic [31:0]                cfg_wdata
);

  typedef struct packed {
    irad_pkg::irad_state_t core;
    logic                  cfg_valid;
    logic                  cfg_write;
    logic [15:0]           cfg_ofs;
    logic [3:0]            cfg_be;
    logic [31:0]           cfg_wdata;
    logic                  hit;
  } irad_all_t;

  irad_all_t   st;
  irad_all_t   next_st;
  logic [15:0] dec_ofs;
  logic [16:0] dec_sel;
  logic        dec_res;
  logic        win_hit;
  logic        ptr_write;

  irad_sel_decode u_sel (
    .ofs      (dec_ofs),
    .sel      (dec_sel),
    .reserved (dec_res)
  );

  function automatic logic [15:0] upper(input logic [31:0] a);
    upper = a[31:16];
  endfunction

  always_comb
  begin
    next_st = st;
    // Window hit on either base, both land on the same offset
    win_hit = req.valid && ((upper(req.addr) == upper(irad_pkg::WIN_BASE_RST)) ||
                            (upper(req.addr) == st.core.base));
    dec_ofs = req.addr[15:0];
    // Pointer lives in the setup block; a full-word write retargets the window
    ptr_write = win_hit && req.write && (dec_ofs == irad_pkg::RELOC_OFS)
                && (req.size == irad_pkg::SIZE_WORD);
    if (ptr_write)
    begin
      next_st.core.base = upper(req.wdata);
    end
    next_st.hit                = win_hit;
    next_st.core.route.valid   = win_hit && !dec_res;
    next_st.core.route.write   = req.write;
    next_st.core.route.sel     = win_hit ? dec_sel : '0;
    next_st.core.route.ofs     = dec_ofs;
    next_st.core.route.wdata   = req.wdata;
    // Other sizes are passed on flagged; outcome left to the controller
    next_st.core.route.size_ok = (req.size == irad_pkg::SIZE_WORD);
    next_st.core.route.reserved = win_hit && dec_res;
    // Anything outside the window is left to the controllers' own decoders
    next_st.core.uncached = req.valid && (req.addr >= irad_pkg::UNC_LO)
                            && (req.addr <= irad_pkg::UNC_HI);
    // Config cycles: any byte enables, lanes never swapped
    next_st.cfg_valid = pci_satellite && pci_cfg_valid;
    next_st.cfg_write = pci_cfg_write;
    next_st.cfg_ofs   = {8'h00, pci_cfg_ofs};
    next_st.cfg_be    = pci_cfg_be;
    next_st.cfg_wdata = pci_cfg_wdata;
    if (rst)
    begin
      next_st = '0;
      next_st.core.base = upper(irad_pkg::WIN_BASE_RST);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    st <= next_st;
  end

  assign route      = st.core.route;
  assign hit        = st.hit;
  assign uncached   = st.core.uncached;
  assign reloc_base = {st.core.base, 16'h0000};
  assign cfg_valid  = st.cfg_valid;
  assign cfg_write  = st.cfg_write;
  assign cfg_ofs    = st.cfg_ofs;
  assign cfg_be     = st.cfg_be;
  assign cfg_wdata  = st.cfg_wdata;

endmodule
`default_nettype wire

// ==== logic/irad_pkg.sv ====
// Purpose: constants and carrier types for the internal register address decoder
// Assumes: 32-bit physical addresses, 64 KB register window
// Notes:   window offsets are the low 16 address bits
package irad_pkg;

  localparam int          ADDR_W        = 32;
  localparam int          OFS_W         = 16;
  localparam int          BASE_W        = 16;
  localparam logic [31:0] WIN_BASE_RST  = 32'hFF1F_0000;
  localparam logic [31:0] UNC_LO        = 32'hFF00_0000;
  localparam logic [31:0] UNC_HI        = 32'hFF3F_FFFF;
  localparam logic [15:0] RELOC_OFS     = 16'hE030;
  localparam logic [2:0]  SIZE_WORD     = 3'h4;

  // Controller select indices
  localparam int SEL_N = 17;
  localparam int S_DMC  = 0;
  localparam int S_EBC  = 1;
  localparam int S_CHP  = 2;
  localparam int S_DMA  = 3;
  localparam int S_NFC  = 4;
  localparam int S_PCI  = 5;
  localparam int S_CFG  = 6;
  localparam int S_TM0  = 7;
  localparam int S_TM1  = 8;
  localparam int S_TM2  = 9;
  localparam int S_SP0  = 10;
  localparam int S_SP1  = 11;
  localparam int S_PAR  = 12;
  localparam int S_ICU  = 13;
  localparam int S_ACL  = 14;
  localparam int S_SPI  = 15;
  localparam int S_RTC  = 16;

  // Range bounds, inclusive
  localparam logic [15:0] R_DMC_LO = 16'h8000;
  localparam logic [15:0] R_DMC_HI = 16'h8FFF;
  localparam logic [15:0] R_EBC_LO = 16'h9000;
  localparam logic [15:0] R_EBC_HI = 16'h9FFF;
  localparam logic [15:0] R_CHP_LO = 16'hA800;
  localparam logic [15:0] R_CHP_HI = 16'hAFFF;
  localparam logic [15:0] R_DMA_LO = 16'hB000;
  localparam logic [15:0] R_DMA_HI = 16'hBFFF;
  localparam logic [15:0] R_NFC_LO = 16'hC000;
  localparam logic [15:0] R_NFC_HI = 16'hCFFF;
  localparam logic [15:0] R_PCI_LO = 16'hD000;
  localparam logic [15:0] R_PCI_HI = 16'hDFFF;
  localparam logic [15:0] R_CFG_LO = 16'hE000;
  localparam logic [15:0] R_CFG_HI = 16'hEFFF;
  localparam logic [15:0] R_TM0_LO = 16'hF000;
  localparam logic [15:0] R_TM0_HI = 16'hF0FF;
  localparam logic [15:0] R_TM1_LO = 16'hF100;
  localparam logic [15:0] R_TM1_HI = 16'hF1FF;
  localparam logic [15:0] R_TM2_LO = 16'hF200;
  localparam logic [15:0] R_TM2_HI = 16'hF2FF;
  localparam logic [15:0] R_SP0_LO = 16'hF300;
  localparam logic [15:0] R_SP0_HI = 16'hF3FF;
  localparam logic [15:0] R_SP1_LO = 16'hF400;
  localparam logic [15:0] R_SP1_HI = 16'hF4FF;
  localparam logic [15:0] R_PAR_LO = 16'hF500;
  localparam logic [15:0] R_PAR_HI = 16'hF50F;
  localparam logic [15:0] R_ICU_LO = 16'hF510;
  localparam logic [15:0] R_ICU_HI = 16'hF6FF;
  localparam logic [15:0] R_ACL_LO = 16'hF700;
  localparam logic [15:0] R_ACL_HI = 16'hF7FF;
  localparam logic [15:0] R_SPI_LO = 16'hF800;
  localparam logic [15:0] R_SPI_HI = 16'hF8FF;
  localparam logic [15:0] R_RTC_LO = 16'hF900;
  localparam logic [15:0] R_RTC_HI = 16'hF9FF;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [2:0]  size;
    logic [31:0] wdata;
  } irad_req_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [16:0]       sel;
    logic [15:0]       ofs;
    logic [31:0]       wdata;
    logic              size_ok;
    logic              reserved;
  } irad_route_t;

  typedef struct packed {
    logic [15:0] base;
    irad_route_t route;
    logic        uncached;
  } irad_state_t;

endpackage

// ==== logic/irad_sel_decode.sv ====
// Purpose: combinational window offset to controller select decode
// Assumes: offset is the low 16 bits of a window hit
// Notes:   ranges are disjoint, so at most one select bit is set
`timescale 1ns/1ps
`default_nettype none
module irad_sel_decode (
  input  wire logic [15:0] ofs,
  output logic      [16:0] sel,
  output logic             reserved
);

  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  always_comb
  begin
    sel = '0;
    sel[irad_pkg::S_DMC] = in_rng(ofs, irad_pkg::R_DMC_LO, irad_pkg::R_DMC_HI);
    sel[irad_pkg::S_EBC] = in_rng(ofs, irad_pkg::R_EBC_LO, irad_pkg::R_EBC_HI);
    sel[irad_pkg::S_CHP] = in_rng(ofs, irad_pkg::R_CHP_LO, irad_pkg::R_CHP_HI);
    sel[irad_pkg::S_DMA] = in_rng(ofs, irad_pkg::R_DMA_LO, irad_pkg::R_DMA_HI);
    sel[irad_pkg::S_NFC] = in_rng(ofs, irad_pkg::R_NFC_LO, irad_pkg::R_NFC_HI);
    sel[irad_pkg::S_PCI] = in_rng(ofs, irad_pkg::R_PCI_LO, irad_pkg::R_PCI_HI);
    sel[irad_pkg::S_CFG] = in_rng(ofs, irad_pkg::R_CFG_LO, irad_pkg::R_CFG_HI);
    sel[irad_pkg::S_TM0] = in_rng(ofs, irad_pkg::R_TM0_LO, irad_pkg::R_TM0_HI);
    sel[irad_pkg::S_TM1] = in_rng(ofs, irad_pkg::R_TM1_LO, irad_pkg::R_TM1_HI);
    sel[irad_pkg::S_TM2] = in_rng(ofs, irad_pkg::R_TM2_LO, irad_pkg::R_TM2_HI);
    sel[irad_pkg::S_SP0] = in_rng(ofs, irad_pkg::R_SP0_LO, irad_pkg::R_SP0_HI);
    sel[irad_pkg::S_SP1] = in_rng(ofs, irad_pkg::R_SP1_LO, irad_pkg::R_SP1_HI);
    sel[irad_pkg::S_PAR] = in_rng(ofs, irad_pkg::R_PAR_LO, irad_pkg::R_PAR_HI);
    sel[irad_pkg::S_ICU] = in_rng(ofs, irad_pkg::R_ICU_LO, irad_pkg::R_ICU_HI);
    sel[irad_pkg::S_ACL] = in_rng(ofs, irad_pkg::R_ACL_LO, irad_pkg::R_ACL_HI);
    sel[irad_pkg::S_SPI] = in_rng(ofs, irad_pkg::R_SPI_LO, irad_pkg::R_SPI_HI);
    sel[irad_pkg::S_RTC] = in_rng(ofs, irad_pkg::R_RTC_LO, irad_pkg::R_RTC_HI);
    reserved = (sel == '0);
  end

endmodule
`default_nettype wire

// ==== verification/irad_master_model.sv ====
// Purpose: bus master model issuing register requests
// Assumes: one request per call, one-cycle strobe
// Notes:   address and data inverted when idle, never left stale
`timescale 1ns/1ps
`default_nettype none
module irad_master_model (
  input  wire logic               sys_clk,
  output var irad_pkg::irad_req_t req
);
  initial req = '0;
  task automatic issue(input logic [31:0] a, input logic [2:0] sz, input logic wr, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{valid: 1'h1, write: wr, addr: a, size: sz, wdata: d}; // Size chosen by caller
    @(posedge sys_clk);
    req <= '{valid: 1'h0, write: 1'h0, addr: ~a, size: sz, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// ==== verification/irad_decoder_asserts.sv ====
// Purpose: port checks of the register window decoder
// Assumes: answers one cycle after the request
// Notes:   only word writes move the window base
`timescale 1ns/1ps
`default_nettype none
module irad_decoder_asserts (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire irad_pkg::irad_req_t   req,
  input wire logic                  pci_satellite,
  input wire logic                  pci_cfg_valid,
  input wire logic [3:0]            pci_cfg_be,
  input wire logic [31:0]           pci_cfg_wdata,
  input wire irad_pkg::irad_route_t route,
  input wire logic                  hit,
  input wire logic                  uncached,
  input wire logic [31:0]           reloc_base,
  input wire logic                  cfg_valid,
  input wire logic [3:0]            cfg_be,
  input wire logic [31:0]           cfg_wdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic win;
  assign win = req.valid && (req.addr[31:16] == 16'hFF1F || req.addr[31:16] == reloc_base[31:16]);
  property p_dflt; $fell(rst) |-> reloc_base == 32'hFF1F_0000; endproperty
  a_dflt: assert property (p_dflt)
    else $error("base not default after reset");
  property p_unc; req.valid |=> uncached == ($past(req.addr) >= 32'hFF00_0000 && $past(req.addr) <= 32'hFF3F_FFFF); endproperty
  a_unc: assert property (p_unc)
    else $error("uncached flag wrong");
  property p_resv; win && !req.addr[15] |=> route.reserved && route.sel == 17'h0 && !route.valid; endproperty
  a_resv: assert property (p_resv)
    else $error("reserved offset selected");
  property p_dmc; win && req.addr[15:12] == 4'h8 |=> route.valid && route.sel == 17'h00001; endproperty
  a_dmc: assert property (p_dmc)
    else $error("memory controller range wrong");
  property p_par; win && req.addr[15:4] == 12'hF50 |=> route.sel == 17'h01000; endproperty
  a_par: assert property (p_par)
    else $error("parallel port range wrong");
  property p_ofs; win |=> hit && {16'h0, route.ofs} == ($past(req.addr) & 32'h0000_FFFF); endproperty
  a_ofs: assert property (p_ofs)
    else $error("window hit or offset wrong");
  property p_miss; req.valid && !win |=> !hit && route.sel == 17'h0; endproperty
  a_miss: assert property (p_miss)
    else $error("outside address selected");
  property p_reloc; win && req.write && req.size == 3'h4 && req.addr[15:0] == 16'hE030
    |=> reloc_base == ($past(req.wdata) & 32'hFFFF_0000); endproperty
  a_reloc: assert property (p_reloc)
    else $error("relocation pointer not loaded");
  property p_cfg; pci_cfg_valid && pci_satellite
    |=> cfg_valid && cfg_be == $past(pci_cfg_be) && cfg_wdata == $past(pci_cfg_wdata); endproperty
  a_cfg: assert property (p_cfg)
    else $error("config cycle not passed unswapped");
  property p_nocfg; !pci_satellite |=> !cfg_valid; endproperty
  a_nocfg: assert property (p_nocfg)
    else $error("config cycle outside satellite mode");
endmodule
bind irad_decoder irad_decoder_asserts i_irad_decoder_asserts (.sys_clk(sys_clk), .rst(rst), .req(req),
  .pci_satellite(pci_satellite), .pci_cfg_valid(pci_cfg_valid), .pci_cfg_be(pci_cfg_be), .route(route),
  .pci_cfg_wdata(pci_cfg_wdata), .hit(hit), .uncached(uncached), .reloc_base(reloc_base),
  .cfg_valid(cfg_valid), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
`default_nettype wire

// ==== verification/irad_decoder_tb.sv ====
// Purpose: self-checking bench for the register window decoder
// Assumes: master model issues requests, bench drives config cycles
// Notes:   answers sampled 1 ns after the edge that registers them
`timescale 1ns/1ps
`default_nettype none
module irad_decoder_tb;
  logic                  sys_clk = 1'h0;
  logic                  rst = 1'h1;
  logic                  pci_satellite = 1'h0;
  logic                  pci_cfg_valid = 1'h0;
  logic                  sys_big_endian = 1'h1;
  logic [3:0]            pci_cfg_be = 4'h0;
  logic [31:0]           pci_cfg_wdata = 32'h0;
  logic [31:0]           reloc_base;
  logic [31:0]           cfg_wdata;
  logic [3:0]            cfg_be;
  logic                  hit;
  logic                  uncached;
  logic                  cfg_valid;
  logic                  cfg_write;
  logic [15:0]           cfg_ofs;
  irad_pkg::irad_req_t   req;
  irad_pkg::irad_route_t route;
  int                    n_fail = 0;
  int                    n_checks = 0;
  irad_master_model i_irad_master_model (.sys_clk(sys_clk), .req(req));
  irad_decoder i_irad_decoder (.sys_clk(sys_clk), .rst(rst), .req(req), .pci_satellite(pci_satellite),
    .pci_cfg_valid(pci_cfg_valid), .pci_cfg_write(1'h1), .pci_cfg_ofs(8'h10), .pci_cfg_be(pci_cfg_be),
    .pci_cfg_wdata(pci_cfg_wdata), .sys_big_endian(sys_big_endian), .route(route), .hit(hit),
    .uncached(uncached), .reloc_base(reloc_base), .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_ofs(cfg_ofs),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rq(input logic [31:0] a, input logic [2:0] sz, input logic wr, input logic [31:0] d);
    i_irad_master_model.issue(a, sz, wr, d);
    #1;
  endtask
  task automatic t_map;
    logic [15:0] ofs [0:21] = '{16'h7FFC, 16'h8000, 16'h9FFC, 16'hA7FC, 16'hA800, 16'hB000, 16'hCFFC,
      16'hD000, 16'hE000, 16'hF0FC, 16'hF100, 16'hF2FC, 16'hF300, 16'hF4FC, 16'hF50C, 16'hF510, 16'hF6FC,
      16'hF700, 16'hF800, 16'hF9FC, 16'hFA00, 16'hFFFC};
    int idx [0:21] = '{-1, 0, 1, -1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 13, 14, 15, 16, -1, -1};
    for (int i = 0; i < 22; i++)
    begin
      rq({16'hFF1F, ofs[i]}, 3'h4, 1'h0, 32'h0);
      chk("sel", 32'(route.sel), idx[i] < 0 ? 32'h0 : 32'h1 << idx[i]);
      chk("reserved", 32'(route.reserved), 32'(idx[i] < 0));
      chk("hit", 32'(hit), 32'h1);
      chk("valid", {30'h0, route.valid, route.size_ok}, {30'h0, idx[i] >= 0, 1'h1});
      chk("ofs", 32'(route.ofs), 32'(ofs[i]));
    end
  endtask
  task automatic t_reloc;
    rq(32'hFF1F_E030, 3'h4, 1'h1, 32'h1234_5678);
    chk("reloc", reloc_base, 32'h1234_0000);
    chk("ptr sel", 32'(route.sel), 32'h40);
    chk("ptr wr", {route.write, route.wdata[30:0]}, 32'h9234_5678);
    rq(32'h1234_F300, 3'h4, 1'h0, 32'h0);
    chk("alias sel", 32'(route.sel), 32'h400);
    chk("alias unc", 32'(uncached), 32'h0);
    rq(32'hFF1F_F300, 3'h4, 1'h0, 32'h0);
    chk("dflt sel", 32'(route.sel), 32'h400);
    rq(32'hFF3F_FFFC, 3'h4, 1'h0, 32'h0);
    chk("unc top", {30'h0, uncached, hit}, 32'h2);
    rq(32'hFF1F_8000, 3'h1, 1'h0, 32'h0);
    chk("size", 32'(route.size_ok), 32'h0);
  endtask
  task automatic t_cfg;
    for (int s = 1; s >= 0; s--)
    begin
      @(posedge sys_clk);
      pci_satellite <= s[0];
      pci_cfg_valid <= 1'h1;
      pci_cfg_be <= 4'h2;
      pci_cfg_wdata <= 32'h1122_3344;
      @(posedge sys_clk);
      pci_cfg_valid <= 1'h0;
      #1;
      chk("cfg valid", 32'(cfg_valid), 32'(s));
      if (s == 1)
      begin
        chk("cfg data", {cfg_be, cfg_wdata[27:0]}, 32'h2122_3344);
        chk("cfg wr ofs", {cfg_write, 15'h0, cfg_ofs}, 32'h8000_0010);
      end
    end
  endtask
  task automatic t_rst;
    @(posedge sys_clk);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk("rst base", reloc_base, 32'hFF1F_0000);
    chk("rst outs", {29'h0, hit, uncached, cfg_valid}, 32'h0);
    // Old relocated base must be gone after reset
    rq(32'h1234_F300, 3'h4, 1'h0, 32'h0);
    chk("rst miss", {15'h0, route.sel}, 32'h0);
    chk("rst hit", 32'(hit), 32'h0);
  endtask
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (2000) @(posedge sys_clk);
    n_fail++;
    conclude;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'h0;
    t_map;
    t_reloc;
    t_cfg;
    t_rst;
    conclude;
  end
endmodule
`default_nettype wire
